// File: design/fll_regs.svh
`ifndef FLL_CTRL_REGS_SVH
`define FLL_CTRL_REGS_SVH
// Overview of operation
// - loop logic runs only while the run enable bit is set, held off otherwise
// - reference source field picks master, bit or frame clock as loop reference
// - selected reference is divided by 1, 2, 4 or 8; result at most 13.5MHz
// - multiplier is integer field plus fraction field whose top bit weighs one half
// - fraction applies only in fractional mode; integer mode ignores it
// - output clock is oscillator frequency divided by the output divider
// - oscillator frequency is divided reference times multiplier times feedback ratio
// - output divider code divides by code plus one, 4 to 64; codes 0 to 2 reserved
// - all frequency relations use the reference after the pre-divider
// - oscillator enable is for free running and is set before run enable
// - source code 00 master, 01 bit, 10 frame clock; 11 reserved
// - pre-divider codes 00, 01, 10, 11 divide by 1, 2, 4, 8

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define FLL_IDX_CTRL1      10'h074
`define FLL_IDX_CTRL2      10'h075
`define FLL_IDX_CTRL3      10'h076
`define FLL_IDX_CTRL4      10'h077
`define FLL_IDX_CTRL5      10'h078
`define FLL_IDX_STATUS     10'h079

// ************************************************************
// field positions
// ************************************************************
`define FLL_RUN_BIT        0
`define FLL_OSC_BIT        1
`define FLL_FRAC_BIT       2
`define OUTPUT_DIVIDER_RNG     13:8
`define FLL_RATE_RNG       6:4
`define FEEDBACK_RATIO_RNG     2:0
`define FLL_MULT_INT_RNG   14:5
`define FLL_MULT_FRAC_RNG  15:0
`define LOOP_GAIN_RNG       3:0
`define FLL_REFDIV_RNG     4:3
`define FLL_REFSRC_RNG     1:0

// ************************************************************
// reset values and codes
// ************************************************************
`define FLL_RST_FRATIO     3'h7
`define FLL_RST_MULT_INT   10'h177
`define OUTPUT_DIVIDER_MIN     6'h03
`define LOOP_GAIN_MAX       4'h8
`define FLL_ERR_SHIFT      4
`define FLL_INC_RST        32'h6147_ae14
`define FLL_SRC_MASTER     2'h0
`define FLL_SRC_BIT        2'h1
`define FLL_SRC_FRAME      2'h2
`define FLL_SRC_RSVD       2'h3
`endif

// File: design/fll_pkg.sv
package fll_pkg;

  typedef struct packed {
    logic        fractional_mode_enable;
    logic        loop_oscillator_enable;
    logic        loop_run_enable;
    logic [5:0]  output_divider;
    logic [2:0]  internal_control_rate;
    logic [2:0]  feedback_ratio;
    logic [15:0] multiplier_fraction;
    logic [9:0]  multiplier_integer;
    logic [3:0]  loop_gain;
    logic [1:0]  reference_predivider;
    logic [1:0]  reference_source_select;
  } fll_cfg_t;

  typedef struct packed {
    logic src_reserved;
    logic outdiv_reserved;
    logic tracking;
    logic osc_running;
  } fll_status_t;

  typedef enum logic [1:0] {
    FLL_OFF,
    FLL_WAIT_REF,
    FLL_FREE,
    FLL_TRACK
  } fll_state_t;

endpackage

// File: design/fll_div.sv
`timescale 1ns/1ps
// ************************************************************
// tick divider: one pulse per limit+1 input ticks
// ************************************************************
module fll_div #(
  parameter int W = 6
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              pulse,
  output logic              level
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         wrap;

  // >= so a limit lowered mid-count wraps at once instead of running round
  assign wrap  = (cnt_q >= limit);
  assign cnt_d = wrap ? {W{1'b0}} : cnt_q + {{(W-1){1'b0}}, 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      pulse <= 1'b0;
      level <= 1'b0;
    end else if (clr) begin
      cnt_q <= '0;
      pulse <= 1'b0;
      level <= 1'b0;
    end else begin
      pulse <= tick & wrap;
      if (tick) begin
        cnt_q <= cnt_d;
        level <= (cnt_d <= (limit >> 1));
      end
    end
  end

endmodule

// File: design/fll_ctrl.sv
`timescale 1ns/1ps
`include "fll_regs.svh"
module fll_ctrl #(
  parameter int AW = 12
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          master_clk_in,
  input  wire logic          bit_clk_in,
  input  wire logic          frame_clk_in,
  output logic               system_clock,
  output logic               loop_running
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [2:0] fll_prediv_lim(input logic [1:0] code);
    fll_prediv_lim = 3'(({1'b0, 3'h1} << code) - 4'h1);
  endfunction

  function automatic logic [31:0] fll_target(input fll_pkg::fll_cfg_t c);
    logic [15:0] keff;
    logic [2:0]  sh;
    keff = c.fractional_mode_enable ? c.multiplier_fraction : 16'h0000;
    sh   = c.feedback_ratio[2] ? 3'h4 : {1'b0, c.feedback_ratio[1:0]};
    fll_target = {6'h00, c.multiplier_integer, keff} << sh;
  endfunction

  function automatic logic [16:0] fll_read(input logic [9:0] idx,
                                           input fll_pkg::fll_cfg_t c,
                                           input fll_pkg::fll_status_t s);
    unique case (idx)
      `FLL_IDX_CTRL1:
        fll_read = {1'b1, 13'h0000, c.fractional_mode_enable,
                    c.loop_oscillator_enable, c.loop_run_enable};
      `FLL_IDX_CTRL2:
        fll_read = {1'b1, 2'h0, c.output_divider, 1'b0, c.internal_control_rate,
                    1'b0, c.feedback_ratio};
      `FLL_IDX_CTRL3:
        fll_read = {1'b1, c.multiplier_fraction};
      `FLL_IDX_CTRL4:
        fll_read = {1'b1, 1'b0, c.multiplier_integer, 1'b0, c.loop_gain};
      `FLL_IDX_CTRL5:
        fll_read = {1'b1, 11'h000, c.reference_predivider, 1'b0,
                    c.reference_source_select};
      `FLL_IDX_STATUS:
        fll_read = {1'b1, 12'h000, s};
      default:
        fll_read = 17'h0_0000;
    endcase
  endfunction

  // ************************************************************
  // apb slave
  // ************************************************************
  fll_pkg::fll_cfg_t    cfg_q;
  fll_pkg::fll_status_t status_w;
  fll_pkg::fll_state_t  state_q;
  fll_pkg::fll_state_t  state_d;

  logic [9:0]  idx_w;
  logic        setup_w;
  logic [16:0] rd_w;
  logic        addr_ok_w;
  logic        wr_en_w;
  logic        wr_ctl1_w;
  logic        wr_ctl2_w;
  logic        wr_ctl3_w;
  logic        wr_ctl4_w;
  logic        wr_ctl5_w;

  assign idx_w     = paddr[11:2];
  assign setup_w   = psel & ~penable;
  assign rd_w      = fll_read(idx_w, cfg_q, status_w);
  // status is read-only, unaligned addresses are refused
  assign addr_ok_w = rd_w[16] & (paddr[1:0] == 2'h0) &
                     ~(pwrite & (idx_w == `FLL_IDX_STATUS));
  assign wr_en_w   = psel & penable & pwrite & pready & ~pslverr;
  assign wr_ctl1_w = wr_en_w & (idx_w == `FLL_IDX_CTRL1);
  assign wr_ctl2_w = wr_en_w & (idx_w == `FLL_IDX_CTRL2);
  assign wr_ctl3_w = wr_en_w & (idx_w == `FLL_IDX_CTRL3);
  assign wr_ctl4_w = wr_en_w & (idx_w == `FLL_IDX_CTRL4);
  assign wr_ctl5_w = wr_en_w & (idx_w == `FLL_IDX_CTRL5);

  // answer decided in setup so every access phase ends after one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~addr_ok_w;
      prdata  <= (setup_w & ~pwrite & addr_ok_w) ? {16'h0000, rd_w[15:0]} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q                   <= '0;
      cfg_q.feedback_ratio    <= `FLL_RST_FRATIO;
      cfg_q.multiplier_integer <= `FLL_RST_MULT_INT;
    end else begin
      if (wr_ctl1_w) begin
        cfg_q.fractional_mode_enable <= pwdata[`FLL_FRAC_BIT];
        cfg_q.loop_oscillator_enable <= pwdata[`FLL_OSC_BIT];
        cfg_q.loop_run_enable        <= pwdata[`FLL_RUN_BIT];
      end
      if (wr_ctl2_w) begin
        cfg_q.output_divider        <= pwdata[`OUTPUT_DIVIDER_RNG];
        cfg_q.internal_control_rate <= pwdata[`FLL_RATE_RNG];
        cfg_q.feedback_ratio        <= pwdata[`FEEDBACK_RATIO_RNG];
      end
      if (wr_ctl3_w) begin
        cfg_q.multiplier_fraction <= pwdata[`FLL_MULT_FRAC_RNG];
      end
      if (wr_ctl4_w) begin
        cfg_q.multiplier_integer <= pwdata[`FLL_MULT_INT_RNG];
        cfg_q.loop_gain          <= pwdata[`LOOP_GAIN_RNG];
      end
      if (wr_ctl5_w) begin
        cfg_q.reference_predivider    <= pwdata[`FLL_REFDIV_RNG];
        cfg_q.reference_source_select <= pwdata[`FLL_REFSRC_RNG];
      end
    end
  end

  // ************************************************************
  // reference selection and pre-division
  // ************************************************************
  logic       run_w;
  logic       ref_sel_w;
  logic       ref_prev_q;
  logic       ref_edge_w;
  logic       fref_tick;
  logic [2:0] prediv_lim_w;

  assign run_w = cfg_q.loop_run_enable;
  // reserved source code leaves the loop without a reference
  assign ref_sel_w =
    (cfg_q.reference_source_select == `FLL_SRC_MASTER) ? master_clk_in :
    (cfg_q.reference_source_select == `FLL_SRC_BIT)    ? bit_clk_in :
    (cfg_q.reference_source_select == `FLL_SRC_FRAME)  ? frame_clk_in : 1'b0;
  assign ref_edge_w   = run_w & ref_sel_w & ~ref_prev_q;
  assign prediv_lim_w = fll_prediv_lim(cfg_q.reference_predivider);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_sel_w;
    end
  end

  // fref_tick is the divided reference that every loop relation uses
  fll_div #(.W(3)) u_prediv (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (~run_w),
    .tick    (ref_edge_w),
    .limit   (prediv_lim_w),
    .pulse   (fref_tick),
    .level   ()
  );

  // ************************************************************
  // sequencing
  // ************************************************************
  logic osc_on_w;

  assign osc_on_w = (state_q == fll_pkg::FLL_FREE) | (state_q == fll_pkg::FLL_TRACK);

  // with the oscillator enable set first the loop runs free until a reference arrives
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fll_pkg::FLL_OFF: begin
        if (run_w & cfg_q.loop_oscillator_enable) begin
          state_d = fll_pkg::FLL_FREE;
        end else if (run_w) begin
          state_d = fll_pkg::FLL_WAIT_REF;
        end
      end
      fll_pkg::FLL_WAIT_REF,
      fll_pkg::FLL_FREE: begin
        if (!run_w) begin
          state_d = fll_pkg::FLL_OFF;
        end else if (fref_tick) begin
          state_d = fll_pkg::FLL_TRACK;
        end
      end
      fll_pkg::FLL_TRACK: begin
        if (!run_w) begin
          state_d = fll_pkg::FLL_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= fll_pkg::FLL_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // digital oscillator and frequency loop
  // ************************************************************
  logic [31:0]        acc_q;
  logic [31:0]        inc_q;
  logic [32:0]        nco_sum_w;
  logic               osc_tick_q;
  logic [15:0]        osc_cnt_q;
  logic [15:0]        osc_cnt_d;
  logic [31:0]        target_w;
  logic signed [32:0] err_w;
  logic [3:0]         gain_w;
  logic signed [41:0] delta_w;
  logic [31:0]        inc_d;

  assign nco_sum_w = {1'b0, acc_q} + {1'b0, inc_q};
  assign target_w  = fll_target(cfg_q);
  assign err_w     = $signed({1'b0, target_w}) - $signed({1'b0, osc_cnt_q, 16'h0000});
  assign gain_w    = (cfg_q.loop_gain > `LOOP_GAIN_MAX) ? `LOOP_GAIN_MAX : cfg_q.loop_gain;
  assign delta_w   = ($signed({{9{err_w[32]}}, err_w}) <<< gain_w) >>> `FLL_ERR_SHIFT;
  // the oscillator rate follows the error between target and counted cycles
  assign inc_d     = inc_q + delta_w[31:0];
  assign osc_cnt_d = fref_tick ? {15'h0000, osc_tick_q} :
                     (&osc_cnt_q) ? osc_cnt_q : osc_cnt_q + {15'h0000, osc_tick_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q      <= 32'h0000_0000;
      inc_q      <= `FLL_INC_RST;
      osc_tick_q <= 1'b0;
      osc_cnt_q  <= 16'h0000;
    end else if (!osc_on_w) begin
      // off or waiting: loop state returns to its start point
      acc_q      <= 32'h0000_0000;
      inc_q      <= `FLL_INC_RST;
      osc_tick_q <= 1'b0;
      osc_cnt_q  <= 16'h0000;
    end else begin
      acc_q      <= nco_sum_w[31:0];
      osc_tick_q <= nco_sum_w[32];
      osc_cnt_q  <= osc_cnt_d;
      if ((state_q == fll_pkg::FLL_TRACK) && fref_tick) begin
        inc_q <= inc_d;
      end
    end
  end

  // ************************************************************
  // output divider
  // ************************************************************
  logic       outdiv_rsvd_w;
  logic [5:0] outdiv_eff_w;
  logic       sys_pulse_w;

  assign outdiv_rsvd_w = (cfg_q.output_divider < `OUTPUT_DIVIDER_MIN);
  // reserved codes fall back to the smallest legal divide
  assign outdiv_eff_w  = outdiv_rsvd_w ? `OUTPUT_DIVIDER_MIN : cfg_q.output_divider;

  fll_div #(.W(6)) u_outdiv (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (~osc_on_w),
    .tick    (osc_tick_q),
    .limit   (outdiv_eff_w),
    .pulse   (sys_pulse_w),
    .level   (system_clock)
  );

  assign status_w.src_reserved    = (cfg_q.reference_source_select == `FLL_SRC_RSVD);
  assign status_w.outdiv_reserved = outdiv_rsvd_w;
  assign status_w.tracking        = (state_q == fll_pkg::FLL_TRACK);
  assign status_w.osc_running     = osc_on_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_running <= 1'b0;
    end else begin
      loop_running <= osc_on_w;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic [4:0] pre_cnt_q;
  logic       pre_ok_q;
  logic [6:0] out_cnt_q;
  logic       out_ok_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= 5'h00;
      pre_ok_q  <= 1'b0;
      out_cnt_q <= 7'h00;
      out_ok_q  <= 1'b0;
    end else begin
      if (!run_w || wr_ctl5_w) begin
        pre_cnt_q <= 5'h00;
        pre_ok_q  <= 1'b0;
      end else if (fref_tick) begin
        pre_cnt_q <= {4'h0, ref_edge_w};
        pre_ok_q  <= 1'b1;
      end else begin
        pre_cnt_q <= pre_cnt_q + {4'h0, ref_edge_w};
      end
      if (!osc_on_w || wr_ctl2_w) begin
        out_cnt_q <= 7'h00;
        out_ok_q  <= 1'b0;
      end else if (sys_pulse_w) begin
        out_cnt_q <= {6'h00, osc_tick_q};
        out_ok_q  <= 1'b1;
      end else begin
        out_cnt_q <= out_cnt_q + {6'h00, osc_tick_q};
      end
    end
  end

  sequence s_start_free;
    state_q == fll_pkg::FLL_OFF && run_w && cfg_q.loop_oscillator_enable;
  endsequence

  sequence s_start_ref;
    state_q == fll_pkg::FLL_OFF && run_w && !cfg_q.loop_oscillator_enable;
  endsequence

  run_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !run_w |=> state_q == fll_pkg::FLL_OFF ##1 (!osc_tick_q && !loop_running))
    else $error("loop still active after run enable cleared");

  osc_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_start_free |=> state_q == fll_pkg::FLL_FREE ##1 (loop_running || !run_w))
    else $error("free running start not taken");

  ref_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_start_ref |=> (state_q == fll_pkg::FLL_WAIT_REF && !osc_tick_q))
    else $error("oscillator started without enable or reference");

  src_pick_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cfg_q.reference_source_select == `FLL_SRC_FRAME && run_w && frame_clk_in &&
     !$past(frame_clk_in)) |-> ref_edge_w)
    else $error("frame clock edge not used as reference");

  src_rsvd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    status_w.src_reserved |-> !ref_edge_w)
    else $error("reserved source produced a reference edge");

  prediv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fref_tick && pre_ok_q) |-> pre_cnt_q == ({2'h0, prediv_lim_w} + 5'h01))
    else $error("reference pre-divide ratio wrong");

  int_mode_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg_q.fractional_mode_enable |-> target_w[15:0] == 16'h0000)
    else $error("fraction used in integer mode");

  frac_weight_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cfg_q.fractional_mode_enable && cfg_q.feedback_ratio[2]) |->
      target_w == {2'h0, cfg_q.multiplier_integer, cfg_q.multiplier_fraction, 4'h0})
    else $error("multiplier weighting wrong");

  outdiv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sys_pulse_w && out_ok_q) |-> out_cnt_q == ({1'b0, outdiv_eff_w} + 7'h01))
    else $error("output divide ratio wrong");

  outdiv_rsvd_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cfg_q.output_divider < `OUTPUT_DIVIDER_MIN) |-> outdiv_eff_w == `OUTPUT_DIVIDER_MIN)
    else $error("reserved output divider code not clamped");

  apb_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_w |=> pready ##1 !pready)
    else $error("apb ready not one cycle after setup");

endmodule

// File: tb/tb.sv
`timescale 1ns/1ps
`include "fll_regs.svh"
module tb;
  typedef struct {
    logic [9:0]  idx;
    logic        wr;
    logic [15:0] wd;
    logic [15:0] rd;
    logic        err;
  } fll_tb_row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mclk;
  logic        bclk;
  logic        fclk;
  logic        system_clock;
  logic        loop_running;
  logic [31:0] rdv;
  logic        erv;
  logic        sc_prev;
  int          mismatches;
  int          checks_done;
  int          cnt;
  real         expv;
  fll_tb_row_t rows [16];
  int          codes [4] = '{0, 3, 7, 63};

  fll_ctrl #(.AW(12)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clk_in(mclk), .bit_clk_in(bclk), .frame_clk_in(fclk),
    .system_clock(system_clock), .loop_running(loop_running));

  always #2 pclk = ~pclk;

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // pready is sampled right after the edge, before the slave's own updates land
  task automatic apb(input logic [9:0] idx, input logic wr, input logic [15:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // one reference period of eight cycles per edge on input sel
  task automatic pulses(input int sel, input int n);
    repeat (n) begin
      @(posedge pclk);
      {fclk, bclk, mclk} <= 3'b001 << sel;
      repeat (4) @(posedge pclk);
      {fclk, bclk, mclk} <= 3'b000;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #(4ns * 60000);
    mismatches++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; mclk = 0; bclk = 0; fclk = 0;
    mismatches = 0; checks_done = 0;
    rows = '{
      '{`FLL_IDX_CTRL1, 0, 0, 16'h0000, 0}, '{`FLL_IDX_CTRL2, 0, 0, 16'h0007, 0},
      '{`FLL_IDX_CTRL3, 0, 0, 16'h0000, 0}, '{`FLL_IDX_CTRL4, 0, 0, 16'h2ee0, 0},
      '{`FLL_IDX_CTRL5, 0, 0, 16'h0000, 0}, '{`FLL_IDX_STATUS, 0, 0, 16'h0004, 0},
      '{`FLL_IDX_CTRL2, 1, 16'hffff, 0, 0}, '{`FLL_IDX_CTRL2, 0, 0, 16'h3f77, 0},
      '{`FLL_IDX_CTRL4, 1, 16'hffff, 0, 0}, '{`FLL_IDX_CTRL4, 0, 0, 16'h7fef, 0},
      '{`FLL_IDX_CTRL5, 1, 16'hffff, 0, 0}, '{`FLL_IDX_STATUS, 1, 16'hffff, 0, 1},
      '{`FLL_IDX_STATUS, 0, 0, 16'h0008, 0}, '{10'h07a, 0, 0, 16'h0000, 1},
      '{`FLL_IDX_CTRL5, 1, 16'h0000, 0, 0}, '{`FLL_IDX_CTRL3, 1, 16'h0000, 0, 0}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check("running after reset", loop_running, 0);
    foreach (rows[i]) begin
      apb(rows[i].idx, rows[i].wr, rows[i].wd);
      if (!rows[i].wr) check("rdata", rdv, {16'h0000, rows[i].rd});
      check("slverr", erv, rows[i].err);
    end
    apb(`FLL_IDX_CTRL4, 1, 16'h2ee0);
    $display("test registers done");
    // free running: output divider codes, reserved code acts as divide by 4
    foreach (codes[i]) begin
      apb(`FLL_IDX_CTRL1, 1, 16'h0000);
      apb(`FLL_IDX_CTRL2, 1, {2'b00, codes[i][5:0], 8'h07});
      apb(`FLL_IDX_CTRL1, 1, 16'h0003);
      repeat (4) @(posedge pclk);
      check("free running", loop_running, 1);
      repeat (6) @(posedge pclk);
      cnt = 0;
      sc_prev = system_clock;
      repeat (4000) begin
        @(posedge pclk);
        if (system_clock === 1'b1 && sc_prev === 1'b0) cnt++;
        sc_prev = system_clock;
      end
      expv = 4000.0 * real'(`FLL_INC_RST) / 4294967296.0 / ((codes[i] < 3) ? 4 : codes[i] + 1);
      check("outdiv edges", (cnt - expv) <= 2.0 && (expv - cnt) <= 2.0, 1);
    end
    apb(`FLL_IDX_CTRL1, 1, 16'h0000);
    repeat (3) @(posedge pclk);
    check("off running", loop_running, 0);
    check("off clock", system_clock, 0);
    pulses(0, 3);
    check("held off", loop_running, 0);
    $display("test free run done");
    // fraction written first, then fractional mode set; both are read back from their registers
    apb(`FLL_IDX_CTRL3, 1, 16'h3127);
    apb(`FLL_IDX_CTRL1, 1, 16'h0004);
    apb(`FLL_IDX_CTRL3, 0, 16'h0000);
    check("fraction", rdv, 32'h0000_3127);
    apb(`FLL_IDX_CTRL1, 0, 16'h0000);
    check("fractional mode", rdv, 32'h0000_0004);
    apb(`FLL_IDX_CTRL1, 1, 16'h0000);
    apb(`FLL_IDX_CTRL3, 1, 16'h0000);
    $display("test fractional mode done");
    // waiting start: only the selected source may start the loop
    for (int s = 0; s < 4; s++) begin
      apb(`FLL_IDX_CTRL1, 1, 16'h0000);
      apb(`FLL_IDX_CTRL5, 1, s[15:0]);
      apb(`FLL_IDX_CTRL1, 1, 16'h0001);
      pulses((s + 1) % 3, 2);
      pulses((s + 2) % 3, 2);
      check("wrong source", loop_running, 0);
      pulses(s % 3, 1);
      check("right source", loop_running, s < 3);
      apb(`FLL_IDX_STATUS, 0, 16'h0000);
      check("status", rdv, (s < 3) ? 32'h0000_0003 : 32'h0000_0008);
    end
    $display("test source select done");
    // pre-divider: start needs exactly 1, 2, 4 or 8 reference edges
    for (int p = 0; p < 4; p++) begin
      apb(`FLL_IDX_CTRL1, 1, 16'h0000);
      apb(`FLL_IDX_CTRL5, 1, 16'(p << 3));
      apb(`FLL_IDX_CTRL1, 1, 16'h0001);
      pulses(0, (1 << p) - 1);
      check("early start", loop_running, 0);
      pulses(0, 1);
      check("divided start", loop_running, 1);
      // a second full period lets the ratio check see a whole count
      pulses(0, 1 << p);
      apb(`FLL_IDX_STATUS, 0, 16'h0000);
      check("divided track", rdv, 32'h0000_0003);
    end
    $display("test pre-divider done");
    // reset in mid-run: outputs drop at once and settings return to defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset running", loop_running, 0);
    check("reset clock", system_clock, 0);
    presetn <= 1'b1;
    apb(`FLL_IDX_CTRL1, 0, 16'h0000);
    check("reset ctrl1", rdv, 32'h0000_0000);
    apb(`FLL_IDX_CTRL2, 0, 16'h0000);
    check("reset ctrl2", rdv, 32'h0000_0007);
    $display("test reset done");
    close_out();
  end
endmodule
